// *** core/csfm_consts.svh ***
// constants for the clock switch and fail-safe monitor
`ifndef CSFM_CONSTS_SVH
`define CSFM_CONSTS_SVH

// ***********************************************************************
// source select codes
// ***********************************************************************
`define CSFM_SEL_PRIMARY    2'h0
`define CSFM_SEL_SECONDARY  2'h1
`define CSFM_SEL_HI_BIT     1
`define CSFM_SEL_RESET      2'h0

// ***********************************************************************
// primary oscillator configuration codes
// ***********************************************************************
`define CSFM_CFG_LP         4'h0
`define CSFM_CFG_XT         4'h1
`define CSFM_CFG_HS         4'h2
`define CSFM_CFG_RC_DIVIDED_CLOCK_OUTPUT  4'h3
`define CSFM_CFG_EC_DIVIDED_CLOCK_OUTPUT  4'h4
`define CSFM_CFG_EC_IO      4'h5
`define CSFM_CFG_RC_IO      4'h6
`define CSFM_CFG_INT_IO     4'h7
`define CSFM_CFG_INT_DIVIDED_CLOCK_OUTPUT 4'h8

// ***********************************************************************
// timing counts
// ***********************************************************************
`define CSFM_OLD_CYCLES     2
`define CSFM_NEW_CYCLES     3
`define CSFM_SAMPLE_DIV     64
`define CSFM_OST_CYCLES     1024
`define CSFM_DIVIDED_CLOCK_OUTPUT_DIV     4

`endif

// *** core/csfm_pkg.sv ***
// types for the clock switch and fail-safe monitor
package csfm_pkg;

	// one-hot system clock sources
	typedef enum logic [2:0] {
		CSFM_SRC_PRIMARY   = 3'h1,
		CSFM_SRC_INTERNAL  = 3'h2,
		CSFM_SRC_SECONDARY = 3'h4
	} csfm_src_t;

	// one-hot switch sequencer states
	typedef enum logic [2:0] {
		CSFM_SW_RUN   = 3'h1,
		CSFM_SW_DRAIN = 3'h2,
		CSFM_SW_WAIT  = 3'h4
	} csfm_sw_state_t;

	typedef struct packed {
		logic       internal_lf_source_sel;
		logic       medium_freq_sel;
		logic [2:0] internal_freq_sel;
	} csfm_int_cfg_t;

	typedef struct packed {
		logic secondary_running_flag;
		logic medium_freq_stable_flag;
		logic low_freq_stable_flag;
		logic high_freq_stable_flag;
		logic startup_done_flag;
	} csfm_status_t;

endpackage

// *** core/csfm_top.sv ***
// clock source switch with glitch-free pause and fail-safe clock monitor
`include "csfm_consts.svh"

//
// Contract
// - pause two old plus three new cycles
// - select 00 uses configured primary source
// - select 10 uses configured internal oscillator
// - select 01 uses secondary oscillator
// - reset clears the source select copy
// - automatic switches leave select; status shows source
// - startup flag shows external source, timer expired
// - monitor only when enabled, all external modes
// - detect failures only after startup timer expiry
// - sample clock is low oscillator over 64
// - latch set primary fall, cleared sample rise
// - fail after sample half-cycle without primary low
// - failure switches internal, sets fail flag
// - interrupt only when fail enable set
// - never return automatically to failed clock
// - fail fallback uses internal frequency field
// - reset or upper select toggle clears condition
// - clearing restarts timer; timeout returns external
// - fail flag clears independently of condition
// - sleep holds second pin low; io modes
// - no startup timer in external clock, rc
module csfm_top #(
	parameter int OST_CYCLES = `CSFM_OST_CYCLES
) (
	input  wire logic                   clk_in,
	input  wire logic                   reset_n_in,
	input  wire logic [1:0]             sys_clk_select_in,
	input  wire logic [3:0]             primary_osc_config_in,
	input  wire logic                   failsafe_enable_cfg_in,
	input  wire csfm_pkg::csfm_int_cfg_t int_cfg_in,
	input  wire logic                   osc_fail_irq_enable_in,
	input  wire logic                   osc_fail_clear_in,
	input  wire logic                   sleep_in,
	input  wire logic                   primary_clk_in,
	input  wire logic                   lf_osc_in,
	input  wire logic                   int_tick_in,
	input  wire logic                   sec_tick_in,
	output csfm_pkg::csfm_src_t         active_src_out,
	output logic                        clk_hold_out,
	output csfm_pkg::csfm_int_cfg_t     int_freq_out,
	output logic [1:0]                  sys_clk_select_out,
	output csfm_pkg::csfm_status_t      status_out,
	output logic                        failsafe_active_out,
	output logic                        osc_fail_flag_out,
	output logic                        osc_fail_irq_out,
	output logic                        osc_pin_out_out,
	output logic                        osc_pin_out_oe_n_out,
	output logic [1:0]                  osc_pins_as_port_out
);

	localparam int OSTW = $clog2(OST_CYCLES + 1);

	// ***********************************************************************
	// mode decoding
	// ***********************************************************************
	function automatic logic is_crystal(input logic [3:0] cfg);
		is_crystal = (cfg == `CSFM_CFG_LP) || (cfg == `CSFM_CFG_XT) ||
			(cfg == `CSFM_CFG_HS) || (cfg > `CSFM_CFG_INT_DIVIDED_CLOCK_OUTPUT);
	endfunction

	function automatic logic is_internal(input logic [3:0] cfg);
		is_internal = (cfg == `CSFM_CFG_INT_IO) || (cfg == `CSFM_CFG_INT_DIVIDED_CLOCK_OUTPUT);
	endfunction

	function automatic logic has_divided_clock_output(input logic [3:0] cfg);
		has_divided_clock_output = (cfg == `CSFM_CFG_RC_DIVIDED_CLOCK_OUTPUT) || (cfg == `CSFM_CFG_EC_DIVIDED_CLOCK_OUTPUT) ||
			(cfg == `CSFM_CFG_INT_DIVIDED_CLOCK_OUTPUT);
	endfunction

	function automatic logic src_tick(input csfm_pkg::csfm_src_t src, input logic p,
			input logic i, input logic s);
		unique case (src)
			csfm_pkg::CSFM_SRC_PRIMARY:   src_tick = p;
			csfm_pkg::CSFM_SRC_SECONDARY: src_tick = s;
			default:                      src_tick = i;
		endcase
	endfunction

	// ***********************************************************************
	// input edges
	// ***********************************************************************
	logic       prim_prev_reg;
	logic       lf_prev_reg;
	logic       sleep_prev_reg;
	logic [1:0] sel_reg;
	logic       sel_hi_s1_reg;
	logic       sel_hi_s2_reg;
	logic       sel_hi_s3_reg;
	logic       prim_rise;
	logic       prim_fall;
	logic       lf_rise;
	logic       wake;
	logic       hi_toggle;
	logic       ext_cfg;

	assign prim_rise = primary_clk_in & ~prim_prev_reg;
	assign prim_fall = ~primary_clk_in & prim_prev_reg;
	assign lf_rise   = lf_osc_in & ~lf_prev_reg;
	assign wake      = sleep_prev_reg & ~sleep_in;
	assign hi_toggle = sel_hi_s2_reg ^ sel_hi_s3_reg;
	assign ext_cfg   = ~is_internal(primary_osc_config_in);

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			prim_prev_reg  <= 1'b0;
			lf_prev_reg    <= 1'b0;
			sleep_prev_reg <= 1'b0;
		end else begin
			prim_prev_reg  <= primary_clk_in;
			lf_prev_reg    <= lf_osc_in;
			sleep_prev_reg <= sleep_in;
		end
	end

	// select copy; automatic switches never write it
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			sel_reg       <= `CSFM_SEL_RESET;
			sel_hi_s1_reg <= 1'b0;
			sel_hi_s2_reg <= 1'b0;
			sel_hi_s3_reg <= 1'b0;
		end else begin
			sel_reg       <= sys_clk_select_in;
			sel_hi_s1_reg <= sys_clk_select_in[`CSFM_SEL_HI_BIT];
			sel_hi_s2_reg <= sel_hi_s1_reg;
			sel_hi_s3_reg <= sel_hi_s2_reg;
		end
	end

	// ***********************************************************************
	// start-up timer
	// ***********************************************************************
	logic [OSTW-1:0] ost_cnt_reg;
	logic            ost_run_reg;
	logic            ost_done_reg;
	logic            ost_restart;
	logic            ost_expire;

	assign ost_restart = hi_toggle | wake;
	// no timer without a crystal: expiry is immediate
	assign ost_expire  = ost_run_reg & (~is_crystal(primary_osc_config_in) |
		(prim_rise & (ost_cnt_reg == OSTW'(OST_CYCLES - 1))));

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			ost_cnt_reg  <= '0;
			ost_run_reg  <= 1'b1;
			ost_done_reg <= 1'b0;
		end else if (ost_restart) begin
			ost_cnt_reg  <= '0;
			ost_run_reg  <= 1'b1;
			ost_done_reg <= 1'b0;
		end else if (ost_expire) begin
			ost_run_reg  <= 1'b0;
			ost_done_reg <= 1'b1;
		end else if (ost_run_reg && prim_rise) begin
			ost_cnt_reg  <= ost_cnt_reg + OSTW'(1);
		end
	end

	// ***********************************************************************
	// fail detector
	// ***********************************************************************
	logic [5:0] div_cnt_reg;
	logic       latch_reg;
	logic       armed_reg;
	logic       fs_reg;
	logic       fs_clr_pend_reg;
	logic       monitor_on;
	logic       sample_rise;
	logic       sample_fall;
	logic       fail_detect;

	assign monitor_on  = failsafe_enable_cfg_in & ext_cfg & ost_done_reg &
		~fs_reg & ~sleep_in;
	assign sample_rise = lf_rise & (div_cnt_reg == 6'h1f);
	assign sample_fall = lf_rise & (div_cnt_reg == 6'h3f);
	// high half of the sample clock ended with no primary low edge
	assign fail_detect = monitor_on & armed_reg & sample_fall & ~latch_reg;

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			div_cnt_reg <= 6'h00;
		end else if (lf_rise) begin
			div_cnt_reg <= div_cnt_reg + 6'h01;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			latch_reg <= 1'b0;
		end else if (prim_fall) begin
			latch_reg <= 1'b1;
		end else if (sample_rise) begin
			latch_reg <= 1'b0;
		end
	end

	// a stale latch must not fail the first half-cycle after enabling
	always_ff @(posedge clk_in) begin
		if (!reset_n_in || !monitor_on) begin
			armed_reg <= 1'b0;
		end else if (sample_rise) begin
			armed_reg <= 1'b1;
		end
	end

	// condition holds until a restarted timer expires
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			fs_reg          <= 1'b0;
			fs_clr_pend_reg <= 1'b0;
		end else if (fail_detect) begin
			fs_reg          <= 1'b1;
			fs_clr_pend_reg <= 1'b0;
		end else if (fs_reg && hi_toggle) begin
			fs_clr_pend_reg <= 1'b1;
		end else if (fs_clr_pend_reg && ost_expire) begin
			fs_reg          <= 1'b0;
			fs_clr_pend_reg <= 1'b0;
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			osc_fail_flag_out <= 1'b0;
			osc_fail_irq_out  <= 1'b0;
		end else begin
			osc_fail_flag_out <= fail_detect | (osc_fail_flag_out & ~osc_fail_clear_in);
			osc_fail_irq_out  <= (fail_detect | (osc_fail_flag_out & ~osc_fail_clear_in)) &
				osc_fail_irq_enable_in;
		end
	end

	// ***********************************************************************
	// source selection and switch sequencer
	// ***********************************************************************
	csfm_pkg::csfm_src_t      target;
	csfm_pkg::csfm_src_t      next_src_reg;
	csfm_pkg::csfm_sw_state_t sw_state_reg;
	logic [1:0]               sw_cnt_reg;
	logic                     old_tick;
	logic                     new_tick;

	always_comb begin
		if (fs_reg) begin
			target = csfm_pkg::CSFM_SRC_INTERNAL;
		end else if (sel_reg[`CSFM_SEL_HI_BIT]) begin
			target = csfm_pkg::CSFM_SRC_INTERNAL;
		end else if (sel_reg == `CSFM_SEL_SECONDARY) begin
			target = csfm_pkg::CSFM_SRC_SECONDARY;
		end else if (ext_cfg && !ost_done_reg) begin
			target = csfm_pkg::CSFM_SRC_INTERNAL;
		end else if (ext_cfg) begin
			target = csfm_pkg::CSFM_SRC_PRIMARY;
		end else begin
			target = csfm_pkg::CSFM_SRC_INTERNAL;
		end
	end

	// a failed primary gives no edges to drain, so its old cycles are skipped
	assign old_tick = src_tick(active_src_out, prim_rise, int_tick_in, sec_tick_in) |
		(fs_reg & (active_src_out == csfm_pkg::CSFM_SRC_PRIMARY));
	assign new_tick = src_tick(next_src_reg, prim_rise, int_tick_in, sec_tick_in);

	// clock stays held through the whole pause, so no runt edge escapes
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			sw_state_reg   <= csfm_pkg::CSFM_SW_RUN;
			sw_cnt_reg     <= 2'h0;
			next_src_reg   <= csfm_pkg::CSFM_SRC_INTERNAL;
			active_src_out <= csfm_pkg::CSFM_SRC_INTERNAL;
			clk_hold_out   <= 1'b0;
		end else begin
			unique case (sw_state_reg)
				csfm_pkg::CSFM_SW_RUN: begin
					if (target != active_src_out) begin
						sw_state_reg <= csfm_pkg::CSFM_SW_DRAIN;
						next_src_reg <= target;
						sw_cnt_reg   <= 2'h0;
						clk_hold_out <= 1'b1;
					end
				end
				csfm_pkg::CSFM_SW_DRAIN: begin
					if (old_tick && sw_cnt_reg == 2'(`CSFM_OLD_CYCLES - 1)) begin
						sw_state_reg <= csfm_pkg::CSFM_SW_WAIT;
						sw_cnt_reg   <= 2'h0;
					end else if (old_tick) begin
						sw_cnt_reg   <= sw_cnt_reg + 2'h1;
					end
				end
				csfm_pkg::CSFM_SW_WAIT: begin
					if (new_tick && sw_cnt_reg == 2'(`CSFM_NEW_CYCLES - 1)) begin
						sw_state_reg   <= csfm_pkg::CSFM_SW_RUN;
						active_src_out <= next_src_reg;
						clk_hold_out   <= 1'b0;
					end else if (new_tick) begin
						sw_cnt_reg     <= sw_cnt_reg + 2'h1;
					end
				end
				default: begin
					sw_state_reg <= csfm_pkg::CSFM_SW_RUN;
					clk_hold_out <= 1'b0;
				end
			endcase
		end
	end

	// ***********************************************************************
	// status and configuration outputs
	// ***********************************************************************
	logic on_int;

	assign on_int = (active_src_out == csfm_pkg::CSFM_SRC_INTERNAL) & ~clk_hold_out;

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			int_freq_out        <= '0;
			sys_clk_select_out  <= `CSFM_SEL_RESET;
			status_out          <= '0;
			failsafe_active_out <= 1'b0;
		end else begin
			int_freq_out        <= int_cfg_in;
			sys_clk_select_out  <= sel_reg;
			failsafe_active_out <= fs_reg;
			status_out.secondary_running_flag  <= ~clk_hold_out &
				(active_src_out == csfm_pkg::CSFM_SRC_SECONDARY);
			status_out.low_freq_stable_flag    <= on_int & (int_cfg_in.internal_freq_sel == 3'h0);
			status_out.medium_freq_stable_flag <= on_int & (int_cfg_in.internal_freq_sel != 3'h0) &
				int_cfg_in.medium_freq_sel;
			status_out.high_freq_stable_flag   <= on_int & (int_cfg_in.internal_freq_sel != 3'h0) &
				~int_cfg_in.medium_freq_sel;
			status_out.startup_done_flag       <= ~clk_hold_out &
				(active_src_out == csfm_pkg::CSFM_SRC_PRIMARY);
		end
	end

	// ***********************************************************************
	// oscillator pins
	// ***********************************************************************
	logic [1:0] divided_clock_output_cnt_reg;
	logic       act_tick;

	assign act_tick = old_tick & ~clk_hold_out;

	// divided clock is a square wave of the running source, frozen in the pause
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			divided_clock_output_cnt_reg <= 2'h0;
		end else if (act_tick) begin
			divided_clock_output_cnt_reg <= divided_clock_output_cnt_reg + 2'h1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			osc_pin_out_out      <= 1'b0;
			osc_pin_out_oe_n_out <= 1'b1;
			osc_pins_as_port_out <= 2'h0;
		end else begin
			osc_pins_as_port_out[1] <= (primary_osc_config_in == `CSFM_CFG_INT_IO);
			osc_pins_as_port_out[0] <= (primary_osc_config_in == `CSFM_CFG_INT_IO) ||
				(primary_osc_config_in == `CSFM_CFG_RC_IO) ||
				(primary_osc_config_in == `CSFM_CFG_EC_IO);
			osc_pin_out_oe_n_out    <= ~has_divided_clock_output(primary_osc_config_in);
			osc_pin_out_out         <= ~sleep_in & has_divided_clock_output(primary_osc_config_in) &
				divided_clock_output_cnt_reg[1];
		end
	end

endmodule // csfm_top

// *** tb/csfm_osc_model.sv ***
// primary oscillator model: runs at a settable rate, or dies parked high
module csfm_osc_model (
	input  wire logic       clk_in,
	input  wire logic       run_in,
	input  wire logic [3:0] half_in,
	output logic            osc_out = 1'b1
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_reg = 4'h0;
	// a dead part stops toggling, so no falling edge reaches the monitor
	always @(posedge clk_in) begin
		if (run_in !== 1'b1) begin
			osc_out <= 1'b1;
		end else if (cnt_reg >= half_in - 4'h1) begin
			osc_out <= ~osc_out;
			cnt_reg <= 4'h0;
		end else begin
			cnt_reg <= cnt_reg + 4'h1;
		end
	end
endmodule // csfm_osc_model

// *** tb/csfm_sva.sv ***
// concurrent checks on the ports of the clock switch and fail-safe monitor
module csfm_sva #(
	parameter int OST_CYCLES = 1024
) (
	input wire logic                   clk_in,
	input wire logic                   reset_n_in,
	input wire logic                   failsafe_enable_cfg_in,
	input wire logic                   osc_fail_irq_enable_in,
	input wire logic                   osc_fail_clear_in,
	input wire csfm_pkg::csfm_src_t    active_src_out,
	input wire logic                   clk_hold_out,
	input wire logic [1:0]             sys_clk_select_out,
	input wire csfm_pkg::csfm_status_t status_out,
	input wire logic                   failsafe_active_out,
	input wire logic                   osc_fail_flag_out,
	input wire logic                   osc_fail_irq_out
);
	// ******
	// checks
	// ******
	localparam csfm_pkg::csfm_src_t SP = csfm_pkg::CSFM_SRC_PRIMARY;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	property p_sel_rst; $rose(reset_n_in) |-> sys_clk_select_out == 2'h0; endproperty
	a_sel_rst: assert property (p_sel_rst) else $error("select copy not cleared");
	// five ticks of two clocks cannot fit in fewer than five cycles
	property p_hold_len; $rose(clk_hold_out) |-> clk_hold_out [*5]; endproperty
	a_hold_len: assert property (p_hold_len) else $error("pause too short");
	property p_hold_end; $fell(clk_hold_out) |-> active_src_out != $past(active_src_out); endproperty
	a_hold_end: assert property (p_hold_end) else $error("pause without switch");
	property p_done;
		status_out.startup_done_flag == $past(active_src_out == SP && !clk_hold_out);
	endproperty
	a_done: assert property (p_done) else $error("startup flag wrong");
	property p_fail; $rose(failsafe_active_out) |-> osc_fail_flag_out ##1 clk_hold_out; endproperty
	a_fail: assert property (p_fail) else $error("fail did not switch");
	property p_no_back;
		failsafe_active_out && $past(failsafe_active_out) && !clk_hold_out |-> active_src_out != SP;
	endproperty
	a_no_back: assert property (p_no_back) else $error("back on failed clock");
	property p_irq; osc_fail_irq_out |-> osc_fail_flag_out && $past(osc_fail_irq_enable_in); endproperty
	a_irq: assert property (p_irq) else $error("interrupt not gated");
	property p_sticky; osc_fail_flag_out && !osc_fail_clear_in |=> osc_fail_flag_out; endproperty
	a_sticky: assert property (p_sticky) else $error("fail flag lost");
	property p_off;
		!$past(failsafe_enable_cfg_in, 2) |-> !$rose(failsafe_active_out);
	endproperty
	a_off: assert property (p_off) else $error("monitor ran while off");
	c_fail: cover property ($rose(failsafe_active_out));
	c_switch: cover property ($fell(clk_hold_out));
	c_clear: cover property ($fell(failsafe_active_out));
endmodule // csfm_sva

bind csfm_top csfm_sva #(.OST_CYCLES(OST_CYCLES)) u_csfm_sva (
	.clk_in, .reset_n_in, .failsafe_enable_cfg_in, .osc_fail_irq_enable_in,
	.osc_fail_clear_in, .active_src_out, .clk_hold_out, .sys_clk_select_out,
	.status_out, .failsafe_active_out, .osc_fail_flag_out, .osc_fail_irq_out
);

// *** tb/testbench.sv ***
// self-checking bench for the clock switch and fail-safe monitor
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	// *********************
	// stimulus and scenarios
	// *********************
	localparam csfm_pkg::csfm_src_t SP = csfm_pkg::CSFM_SRC_PRIMARY;
	localparam csfm_pkg::csfm_src_t SI = csfm_pkg::CSFM_SRC_INTERNAL;
	localparam csfm_pkg::csfm_src_t SS = csfm_pkg::CSFM_SRC_SECONDARY;
	logic                    clk = 1'b0;
	logic                    rst_n = 1'b0;
	logic [1:0]              sel = 2'h0;
	logic [3:0]              cfg = 4'h1;
	logic                    fs_en = 1'b1;
	logic                    irq_en = 1'b0;
	logic                    fclr = 1'b0;
	logic                    slp = 1'b0;
	logic                    run = 1'b1;
	logic [3:0]              half = 4'h4;
	logic [7:0]              ph = 8'h0;
	csfm_pkg::csfm_int_cfg_t icfg = 5'h0d;
	csfm_pkg::csfm_src_t     src;
	csfm_pkg::csfm_int_cfg_t ifreq;
	csfm_pkg::csfm_status_t  st;
	logic                    pclk, hold, fs, flag, irq, pin, oe_n;
	logic [1:0]              sel_o, port;
	int                      num_errors = 0;
	int                      n_tests = 0;
	int                      cyc = 0;

	csfm_osc_model u_csfm_osc_model (.clk_in(clk), .run_in(run), .half_in(half), .osc_out(pclk));
	csfm_top #(.OST_CYCLES(4)) u_csfm_top (
		.clk_in(clk), .reset_n_in(rst_n), .sys_clk_select_in(sel),
		.primary_osc_config_in(cfg), .failsafe_enable_cfg_in(fs_en), .int_cfg_in(icfg),
		.osc_fail_irq_enable_in(irq_en), .osc_fail_clear_in(fclr), .sleep_in(slp),
		.primary_clk_in(pclk), .lf_osc_in(ph[1]), .int_tick_in(ph[0]),
		.sec_tick_in(&ph[3:0]), .active_src_out(src), .clk_hold_out(hold),
		.int_freq_out(ifreq), .sys_clk_select_out(sel_o), .status_out(st),
		.failsafe_active_out(fs), .osc_fail_flag_out(flag), .osc_fail_irq_out(irq),
		.osc_pin_out_out(pin), .osc_pin_out_oe_n_out(oe_n), .osc_pins_as_port_out(port)
	);

	always #4 clk = ~clk;
	// low oscillator period 4 cycles, so one sample half-cycle is 128 cycles
	always @(posedge clk) ph <= #1 ph + 8'h1;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h got %h", nm, exp, got);
		end
	endtask

	task automatic chk1(input string nm, input logic exp, input logic got);
		chk(nm, 8'(exp), 8'(got));
	endtask

	function automatic int tk(input csfm_pkg::csfm_src_t s, input logic pr);
		return (s == SP) ? int'(pr) : (s == SI) ? int'(ph[0]) : int'(&ph[3:0]);
	endfunction

	task automatic wait_src(input csfm_pkg::csfm_src_t ns, input int lim);
		for (int n = 0; n < lim && src !== ns; n++)
			step(1);
		chk("src", 8'(ns), 8'(src));
	endtask

	task automatic wait_fs(input logic v, input int lim);
		for (int n = 0; n < lim && fs !== v; n++)
			step(1);
		chk1("failsafe", v, fs);
	endtask

	task automatic do_reset(input logic [3:0] c, input logic en);
		rst_n = 1'b0;
		cfg = c;
		fs_en = en;
		step(16);
		rst_n = 1'b1;
		step(1);
	endtask

	// ticks are counted from the select change, so early ones only make it lenient
	task automatic sw(input logic [1:0] s, input csfm_pkg::csfm_src_t ns, input logic [4:0] e);
		csfm_pkg::csfm_src_t os;
		int o, w, seen;
		logic p, pr;
		os = src;
		o = 0;
		w = 0;
		seen = 0;
		p = pclk;
		sel = s;
		for (int n = 0; n < 400; n++) begin
			step(1);
			pr = pclk & ~p;
			p = pclk;
			o += tk(os, pr);
			w += tk(ns, pr);
			if (hold === 1'b1)
				seen = 1;
			else if (seen == 1)
				break;
		end
		chk("src", 8'(ns), 8'(src));
		chk1("old ticks", 1'b1, o >= 2);
		chk1("new ticks", 1'b1, w >= 3);
		step(1);
		chk("status", 8'(e), 8'(st));
	endtask

	task automatic t_startup();
		chk("sel copy", 8'h0, 8'(sel_o));
		chk("src", 8'(SI), 8'(src));
		wait_src(SP, 200);
	endtask

	task automatic t_switch();
		sw(2'h1, SS, 5'h10);
		sw(2'h2, SI, 5'h08);
		chk("int cfg", 8'(icfg), 8'(ifreq));
		sw(2'h0, SP, 5'h01);
	endtask

	task automatic t_fail();
		half = 4'hf;
		step(700);
		chk1("slow clock", 1'b0, fs);
		half = 4'h4;
		run = 1'b0;
		wait_fs(1'b1, 1500);
		chk1("flag", 1'b1, flag);
		chk1("irq off", 1'b0, irq);
		chk("sel copy", 8'h0, 8'(sel_o));
		irq_en = 1'b1;
		step(2);
		chk1("irq on", 1'b1, irq);
		wait_src(SI, 300);
		step(1);
		chk("status", 8'h08, 8'(st));
		run = 1'b1;
		step(300);
		chk("src", 8'(SI), 8'(src));
		fclr = 1'b1;
		step(1);
		fclr = 1'b0;
		step(1);
		chk1("flag clear", 1'b0, flag);
		chk1("kept", 1'b1, fs);
		sel = 2'h2;
		step(4);
		sel = 2'h0;
		step(4);
		chk1("timer run", 1'b1, fs);
		wait_fs(1'b0, 400);
		wait_src(SP, 400);
	endtask

	task automatic t_reset();
		run = 1'b0;
		wait_fs(1'b1, 1500);
		sel = 2'h2;
		rst_n = 1'b0;
		step(3);
		chk("sel copy", 8'h0, 8'(sel_o));
		chk1("cond", 1'b0, fs);
		sel = 2'h0;
		run = 1'b1;
		do_reset(4'h5, 1'b0);
		wait_src(SP, 40);
		run = 1'b0;
		step(1500);
		chk1("monitor off", 1'b0, fs);
		run = 1'b1;
	endtask

	task automatic t_pins();
		int hi;
		for (int i = 3; i <= 8; i++) begin
			do_reset(4'(i), 1'b1);
			slp = 1'b1;
			step(3);
			chk("port", (i == 7) ? 8'h3 : (i == 5 || i == 6) ? 8'h1 : 8'h0, 8'(port));
			chk1("drive", i == 5 || i == 6 || i == 7, oe_n);
			if (oe_n === 1'b0)
				chk1("sleep pin", 1'b0, pin);
			slp = 1'b0;
			hi = 0;
			for (int n = 0; n < 80; n++) begin
				step(1);
				hi |= int'(pin === 1'b1);
			end
			chk1("divided_clock_output", i == 3 || i == 4 || i == 8, hi != 0);
		end
	endtask

	task automatic end_of_test();
		if (num_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		do_reset(4'h1, 1'b1);
		t_startup();
		t_switch();
		t_fail();
		t_reset();
		t_pins();
		end_of_test();
	end
endmodule // testbench
